// ---- hw/tcc_timers.sv ----
// timer2 and timer3 block with byte register file and timer1 low byte view
//
// Operation
// - timer2 halts after four received bits if enabled
// - timer2 stop-on-receive ignored in trimming modes
// - timer2 auto start: none, tx end, trimming
// - timer2 reloads at zero or stops; no-underflow trimming holds at zero
// - timer2 underflow sets its flag
// - timer2 clock 13.56 MHz or 212 kHz
// - timer2 clocked by timer0 or timer1 underflow
// - timer2 start loads reload; writes wait
// - counts readable as high and low bytes
// - timer3 halts after four bits, not trimming
// - timer3 auto start decoded like timer2
// - timer3 reloads at zero or stops; no-underflow trimming holds at zero
// - timer3 underflow sets its own flag
// - timer3 clock 13.56 MHz or 212 kHz
// - timer3 clocked by timer0 or timer1 underflow
// - timer3 start loads reload; writes wait
// - timer1 count low byte readable at 18h
// - bit 6 shows timer2 active, gated write
// - bit 7 shows timer3 active, gated write
`timescale 1ns/1ns
`default_nettype none

module tcc_timers (
  // clock and reset
  input wire logic mclk_in,
  input wire logic resetn_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // timer input clocks, one-cycle ticks
  input wire logic tick_13m56_in,
  input wire logic tick_212k_in,
  // sibling timers
  input wire logic timer0_underflow_in,
  input wire logic timer1_underflow_in,
  input wire logic [7:0] timer1_count_low_in,
  // transceiver events
  input wire logic tx_end_in,
  input wire logic rx_first_bits_in,
  input wire logic low_frequency_oscillator_in,
  // flag clears from the interrupt logic
  input wire logic timer2_flag_clear_in,
  input wire logic timer3_flag_clear_in,
  // timer status
  output logic timer2_underflow_flag_out,
  output logic timer3_underflow_flag_out,
  output logic timer2_underflow_out,
  output logic timer3_underflow_out,
  output logic timer2_active_out,
  output logic timer3_active_out
);

  // ****************************************************
  // declarations
  // ****************************************************
  logic [7:0] ctrl_q [2]; // control bytes, index 0 timer2, 1 timer3
  logic [7:0] reload_hi_q [2]; // reload high parts
  logic [7:0] reload_lo_q [2]; // reload low parts
  logic [15:0] count [2]; // live counts
  logic [1:0] running; // live run state
  logic [1:0] underflow; // underflow strobes
  logic [1:0] flag_q; // sticky underflow flags
  logic [1:0] flag_clear; // clear requests per timer
  logic lfo_q; // previous oscillator level
  logic lfo_rise; // oscillator positive edge
  logic run_wr; // write to shared run control
  logic [7:0] rdata_q; // registered read data
  logic [7:0] rdata_d; // read mux result
  logic [7:0] shared_view; // shared run control read value

  assign flag_clear = {timer3_flag_clear_in, timer2_flag_clear_in};
  assign run_wr = reg_wr_in && (reg_addr_in == tcc_pkg::ADDR_SHARED_RUN_CTRL);

  // ****************************************************
  // oscillator edge detect
  // ****************************************************
  // previous level of the oscillator input, synchronous by contract
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lfo_q <= 1'b0;
    end else begin
      lfo_q <= low_frequency_oscillator_in;
    end
  end

  // trimming starts and stops on rising edges
  assign lfo_rise = low_frequency_oscillator_in & ~lfo_q;

  // ****************************************************
  // per timer logic
  // ****************************************************
  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_timer
      // per-timer decoded addresses
      logic [7:0] a_ctrl; // control address
      logic [7:0] a_rhi; // reload high address
      logic [7:0] a_rlo; // reload low address
      logic [1:0] start_mode; // auto start field
      logic [1:0] clk_sel; // clock select field
      logic trimming; // either trimming mode
      logic tick; // selected input tick
      logic run_wren; // run write enable bit in this write
      logic run_val; // run value bit in this write
      logic sw_start; // software start
      logic sw_stop; // software stop
      logic trim_start; // trimming start edge
      logic trim_stop; // trimming stop edge
      logic rx_stop; // stop after first received bits
      logic start; // any start event
      logic stop; // any stop event

      // timer2 uses 19h..1Bh, timer3 1Eh..20h
      assign a_ctrl = (i == 0) ? tcc_pkg::ADDR_T2_CONTROL : tcc_pkg::ADDR_T3_CONTROL;
      assign a_rhi = (i == 0) ? tcc_pkg::ADDR_T2_RELOAD_HI : tcc_pkg::ADDR_T3_RELOAD_HI;
      assign a_rlo = (i == 0) ? tcc_pkg::ADDR_T2_RELOAD_LO : tcc_pkg::ADDR_T3_RELOAD_LO;

      // control byte, reserved bits held at zero
      always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          ctrl_q[i] <= tcc_pkg::CTRL_RESET;
        end else if (reg_wr_in && reg_addr_in == a_ctrl) begin
          ctrl_q[i] <= reg_wdata_in & tcc_pkg::CTRL_WRITE_MASK;
        end
      end

      // reload bytes reach the counter only at a start or an auto reload at zero
      always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          reload_hi_q[i] <= tcc_pkg::RELOAD_RESET;
          reload_lo_q[i] <= tcc_pkg::RELOAD_RESET;
        end else if (reg_wr_in) begin
          if (reg_addr_in == a_rhi) begin
            reload_hi_q[i] <= reg_wdata_in;
          end
          if (reg_addr_in == a_rlo) begin
            reload_lo_q[i] <= reg_wdata_in;
          end
        end
      end

      // field extraction
      assign start_mode = ctrl_q[i][tcc_pkg::CTRL_START_LSB +: 2];
      assign clk_sel = ctrl_q[i][tcc_pkg::CTRL_CLK_LSB +: 2];
      // both trimming codes share the top bit
      assign trimming = (start_mode == tcc_pkg::START_TRIM_NOWRAP) ||
                        (start_mode == tcc_pkg::START_TRIM_WRAP);

      // input tick selection
      always_comb begin
        unique case (clk_sel)
          tcc_pkg::CLK_SEL_FAST: tick = tick_13m56_in;
          tcc_pkg::CLK_SEL_SLOW: tick = tick_212k_in;
          tcc_pkg::CLK_SEL_T0: tick = timer0_underflow_in;
          tcc_pkg::CLK_SEL_T1: tick = timer1_underflow_in;
        endcase
      end

      // gated run writes
      assign run_wren = (i == 0) ? reg_wdata_in[tcc_pkg::RUN_T2_WREN_BIT] :
                                   reg_wdata_in[tcc_pkg::RUN_T3_WREN_BIT];
      assign run_val = (i == 0) ? reg_wdata_in[tcc_pkg::RUN_T2_ACTIVE_BIT] :
                                  reg_wdata_in[tcc_pkg::RUN_T3_ACTIVE_BIT];
      assign sw_start = run_wr & run_wren & run_val;
      assign sw_stop = run_wr & run_wren & ~run_val;

      // trimming: a rising edge starts an idle timer, stops a running one
      assign trim_start = trimming & lfo_rise & ~running[i];
      assign trim_stop = trimming & lfo_rise & running[i];

      // receive stop, disabled while trimming
      assign rx_stop = ctrl_q[i][tcc_pkg::CTRL_STOP_RX_BIT] & ~trimming & rx_first_bits_in;

      // start events: software, end of transmission, trimming edge
      assign start = sw_start | trim_start |
                     ((start_mode == tcc_pkg::START_TX_END) & tx_end_in);
      assign stop = sw_stop | trim_stop | rx_stop;

      // the counter itself; no-underflow trimming holds at zero
      tcc_timer_core u_core (
        .mclk_in(mclk_in),
        .resetn_in(resetn_in),
        .tick_in(tick),
        .start_in(start),
        .stop_in(stop),
        .reload_in({reload_hi_q[i], reload_lo_q[i]}),
        .auto_reload_in(ctrl_q[i][tcc_pkg::CTRL_RELOAD_BIT]),
        .wrap_en_in(start_mode != tcc_pkg::START_TRIM_NOWRAP),
        .count_out(count[i]),
        .running_out(running[i]),
        .underflow_out(underflow[i])
      );

      // sticky flag, a new underflow wins over a clear
      always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
          flag_q[i] <= 1'b0;
        end else if (underflow[i]) begin
          flag_q[i] <= 1'b1;
        end else if (flag_clear[i]) begin
          flag_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // ****************************************************
  // read path
  // ****************************************************
  // shared run control shows live run state in bits 7 and 6
  always_comb begin
    shared_view = tcc_pkg::READ_ZERO;
    shared_view[tcc_pkg::RUN_T2_ACTIVE_BIT] = running[0];
    shared_view[tcc_pkg::RUN_T3_ACTIVE_BIT] = running[1];
  end

  // byte mux; unmapped addresses read zero
  always_comb begin
    unique case (reg_addr_in)
      tcc_pkg::ADDR_SHARED_RUN_CTRL: rdata_d = shared_view;
      tcc_pkg::ADDR_T1_COUNT_LO: rdata_d = timer1_count_low_in;
      tcc_pkg::ADDR_T2_CONTROL: rdata_d = ctrl_q[0];
      tcc_pkg::ADDR_T2_RELOAD_HI: rdata_d = reload_hi_q[0];
      tcc_pkg::ADDR_T2_RELOAD_LO: rdata_d = reload_lo_q[0];
      tcc_pkg::ADDR_T2_COUNT_HI: rdata_d = count[0][15:8];
      tcc_pkg::ADDR_T2_COUNT_LO: rdata_d = count[0][7:0];
      tcc_pkg::ADDR_T3_CONTROL: rdata_d = ctrl_q[1];
      tcc_pkg::ADDR_T3_RELOAD_HI: rdata_d = reload_hi_q[1];
      tcc_pkg::ADDR_T3_RELOAD_LO: rdata_d = reload_lo_q[1];
      tcc_pkg::ADDR_T3_COUNT_HI: rdata_d = count[1][15:8];
      tcc_pkg::ADDR_T3_COUNT_LO: rdata_d = count[1][7:0];
      default: rdata_d = tcc_pkg::READ_ZERO;
    endcase
  end

  // read data captured on a read strobe and held until the next
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_q <= tcc_pkg::READ_ZERO;
    end else if (reg_rd_in) begin
      rdata_q <= rdata_d;
    end
  end

  // ****************************************************
  // outputs
  // ****************************************************
  assign reg_rdata_out = rdata_q;
  assign timer2_underflow_flag_out = flag_q[0];
  assign timer3_underflow_flag_out = flag_q[1];
  assign timer2_underflow_out = underflow[0];
  assign timer3_underflow_out = underflow[1];
  assign timer2_active_out = running[0];
  assign timer3_active_out = running[1];

endmodule

`default_nettype wire

// ---- hw/tcc_pkg.sv ----
// constants shared by the timer2/timer3 block and its counter core
package tcc_pkg;

  // ****************************************************
  // register byte addresses
  // ****************************************************
  localparam logic [7:0] ADDR_SHARED_RUN_CTRL = 8'h0E; // shared run control
  localparam logic [7:0] ADDR_T1_COUNT_LO = 8'h18; // timer1 count low, read only
  localparam logic [7:0] ADDR_T2_CONTROL = 8'h19; // timer2 control
  localparam logic [7:0] ADDR_T2_RELOAD_HI = 8'h1A; // timer2 reload high
  localparam logic [7:0] ADDR_T2_RELOAD_LO = 8'h1B; // timer2 reload low
  localparam logic [7:0] ADDR_T2_COUNT_HI = 8'h1C; // timer2 count high, read only
  localparam logic [7:0] ADDR_T2_COUNT_LO = 8'h1D; // timer2 count low, read only
  localparam logic [7:0] ADDR_T3_CONTROL = 8'h1E; // timer3 control
  localparam logic [7:0] ADDR_T3_RELOAD_HI = 8'h1F; // timer3 reload high
  localparam logic [7:0] ADDR_T3_RELOAD_LO = 8'h20; // timer3 reload low
  localparam logic [7:0] ADDR_T3_COUNT_HI = 8'h21; // timer3 count high, read only
  localparam logic [7:0] ADDR_T3_COUNT_LO = 8'h22; // timer3 count low, read only

  // ****************************************************
  // control register field positions
  // ****************************************************
  localparam int CTRL_STOP_RX_BIT = 7; // stop on receive
  localparam int CTRL_START_LSB = 4; // auto start mode, two bits
  localparam int CTRL_RELOAD_BIT = 3; // auto reload
  localparam int CTRL_CLK_LSB = 0; // clock select, two bits
  localparam logic [7:0] CTRL_WRITE_MASK = 8'hBB; // bits 6 and 2 reserved

  // ****************************************************
  // shared run control field positions
  // ****************************************************
  localparam int RUN_T3_ACTIVE_BIT = 7; // timer3 active
  localparam int RUN_T2_ACTIVE_BIT = 6; // timer2 active
  localparam int RUN_T3_WREN_BIT = 3; // timer3 run write enable
  localparam int RUN_T2_WREN_BIT = 2; // timer2 run write enable

  // ****************************************************
  // field encodings and reset values
  // ****************************************************
  localparam logic [1:0] START_NONE = 2'h0; // no automatic start
  localparam logic [1:0] START_TX_END = 2'h1; // start at end of transmission
  localparam logic [1:0] START_TRIM_NOWRAP = 2'h2; // trimming, no underflow
  localparam logic [1:0] START_TRIM_WRAP = 2'h3; // trimming with underflow
  localparam logic [1:0] CLK_SEL_FAST = 2'h0; // 13.56 MHz tick
  localparam logic [1:0] CLK_SEL_SLOW = 2'h1; // 212 kHz tick
  localparam logic [1:0] CLK_SEL_T0 = 2'h2; // timer0 underflow
  localparam logic [1:0] CLK_SEL_T1 = 2'h3; // timer1 underflow
  localparam logic [7:0] CTRL_RESET = 8'h00; // control after reset
  localparam logic [7:0] RELOAD_RESET = 8'h00; // reload bytes after reset
  localparam logic [15:0] COUNT_RESET = 16'h0000; // counter after reset
  localparam logic [7:0] READ_ZERO = 8'h00; // unmapped read answer

endpackage

// ---- hw/tcc_timer_core.sv ----
// one 16-bit down counter with start, stop, reload and underflow strobe
`timescale 1ns/1ns
`default_nettype none

module tcc_timer_core (
  // clock and reset
  input wire logic mclk_in,
  input wire logic resetn_in,
  // control events
  input wire logic tick_in,
  input wire logic start_in,
  input wire logic stop_in,
  // configuration
  input wire logic [15:0] reload_in,
  input wire logic auto_reload_in,
  input wire logic wrap_en_in,
  // state
  output logic [15:0] count_out,
  output logic running_out,
  output logic underflow_out
);

  logic [15:0] count_q; // current count
  logic running_q; // counting
  logic at_zero; // count is zero
  logic wrap; // zero decremented this cycle

  assign at_zero = (count_q == tcc_pkg::COUNT_RESET);
  // underflow when a running counter at zero takes a tick with wrap enabled and no start or stop
  assign wrap = running_q & tick_in & at_zero & wrap_en_in & ~start_in & ~stop_in;

  // ****************************************************
  // counter
  // ****************************************************
  // start loads reload word; tick decrements or reloads at zero
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count_q <= tcc_pkg::COUNT_RESET;
    end else if (start_in) begin
      count_q <= reload_in;
    end else if (stop_in) begin
      count_q <= count_q; // halted, value kept
    end else if (wrap && auto_reload_in) begin
      count_q <= reload_in;
    end else if (running_q && tick_in && !at_zero) begin
      count_q <= count_q - 16'h0001;
    end
  end

  // ****************************************************
  // run state
  // ****************************************************
  // start wins over stop; underflow without reload stops
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      running_q <= 1'b0;
    end else if (start_in) begin
      running_q <= 1'b1;
    end else if (stop_in) begin
      running_q <= 1'b0;
    end else if (wrap && !auto_reload_in) begin
      running_q <= 1'b0;
    end
  end

  assign count_out = count_q;
  assign running_out = running_q;
  assign underflow_out = wrap;

endmodule

`default_nettype wire

// ---- test/tcc_timers_asserts.sv ----
// port-level checks for the timer2/timer3 block
`timescale 1ns/1ns
`default_nettype none

module tcc_timers_asserts (
  // clock and reset
  input wire logic mclk_in,
  input wire logic resetn_in,
  // register port
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  // ticks and events
  input wire logic tick_13m56_in,
  input wire logic tick_212k_in,
  input wire logic timer0_underflow_in,
  input wire logic timer1_underflow_in,
  input wire logic [7:0] timer1_count_low_in,
  input wire logic tx_end_in,
  input wire logic rx_first_bits_in,
  input wire logic low_frequency_oscillator_in,
  // status
  input wire logic timer2_underflow_flag_out,
  input wire logic timer3_underflow_flag_out,
  input wire logic timer2_underflow_out,
  input wire logic timer3_underflow_out,
  input wire logic timer2_active_out,
  input wire logic timer3_active_out
);
  // ****************************************************
  // shadow control bytes and tick sources
  // ****************************************************
  logic [7:0] ctrl2_q; // timer2 control as written
  logic [7:0] ctrl3_q; // timer3 control as written
  logic [3:0] tk; // ticks in clock select order
  logic wr_run; // write to shared run control
  assign tk = {timer1_underflow_in, timer0_underflow_in, tick_212k_in, tick_13m56_in};
  assign wr_run = reg_wr_in && (reg_addr_in == tcc_pkg::ADDR_SHARED_RUN_CTRL);
  // follow control writes so checks know the mode
  always_ff @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctrl2_q <= 8'h00;
      ctrl3_q <= 8'h00;
    end else if (reg_wr_in) begin
      ctrl2_q <= (reg_addr_in == tcc_pkg::ADDR_T2_CONTROL) ? reg_wdata_in : ctrl2_q;
      ctrl3_q <= (reg_addr_in == tcc_pkg::ADDR_T3_CONTROL) ? reg_wdata_in : ctrl3_q;
    end
  end
  // ****************************************************
  // properties
  // ****************************************************
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  property p_t2_flag; timer2_underflow_out |=> timer2_underflow_flag_out; endproperty
  a_t2_flag: assert property (p_t2_flag) else $error("flag2 not set");
  property p_t3_flag; timer3_underflow_out |=> timer3_underflow_flag_out; endproperty
  a_t3_flag: assert property (p_t3_flag) else $error("flag3 not set");
  property p_t2_rxstop;
    rx_first_bits_in && ctrl2_q[7] && !ctrl2_q[5] && !reg_wr_in && !tx_end_in
      |=> !timer2_active_out;
  endproperty
  a_t2_rxstop: assert property (p_t2_rxstop) else $error("rx stop missed");
  property p_t2_trim_rx;
    rx_first_bits_in && ctrl2_q[5] && timer2_active_out && !reg_wr_in && !tk[ctrl2_q[1:0]]
      && !$rose(low_frequency_oscillator_in) |=> timer2_active_out;
  endproperty
  a_t2_trim_rx: assert property (p_t2_trim_rx) else $error("rx stop in trim");
  property p_t2_txstart;
    tx_end_in && (ctrl2_q[5:4] == 2'h1) && !reg_wr_in |=> timer2_active_out;
  endproperty
  a_t2_txstart: assert property (p_t2_txstart) else $error("tx start missed");
  property p_t2_oneshot;
    timer2_underflow_out && !ctrl2_q[3] && !reg_wr_in && !tx_end_in
      && !$rose(low_frequency_oscillator_in) |=> !timer2_active_out;
  endproperty
  a_t2_oneshot: assert property (p_t2_oneshot) else $error("no stop at end");
  property p_t2_tick; timer2_underflow_out |-> timer2_active_out && tk[ctrl2_q[1:0]]; endproperty
  a_t2_tick: assert property (p_t2_tick) else $error("t2 bad tick");
  property p_t3_tick; timer3_underflow_out |-> timer3_active_out && tk[ctrl3_q[1:0]]; endproperty
  a_t3_tick: assert property (p_t3_tick) else $error("t3 bad tick");
  property p_run2;
    wr_run && reg_wdata_in[2] && (reg_wdata_in[6] || !(tx_end_in
      || $rose(low_frequency_oscillator_in))) |=> timer2_active_out == $past(reg_wdata_in[6]);
  endproperty
  a_run2: assert property (p_run2) else $error("t2 run write");
  property p_run3;
    wr_run && reg_wdata_in[3] && (reg_wdata_in[7] || !(tx_end_in
      || $rose(low_frequency_oscillator_in))) |=> timer3_active_out == $past(reg_wdata_in[7]);
  endproperty
  a_run3: assert property (p_run3) else $error("t3 run write");
  property p_t1_low;
    reg_rd_in && (reg_addr_in == tcc_pkg::ADDR_T1_COUNT_LO)
      |=> reg_rdata_out == $past(timer1_count_low_in);
  endproperty
  a_t1_low: assert property (p_t1_low) else $error("t1 low read");
  c_t2_uf: cover property (timer2_underflow_out);
  c_t3_uf: cover property (timer3_underflow_out);
  c_rx_run: cover property (rx_first_bits_in && timer2_active_out);
endmodule

bind tcc_timers tcc_timers_asserts i_tcc_timers_asserts (
  .mclk_in(mclk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .tick_13m56_in(tick_13m56_in), .tick_212k_in(tick_212k_in),
  .timer0_underflow_in(timer0_underflow_in), .timer1_underflow_in(timer1_underflow_in),
  .timer1_count_low_in(timer1_count_low_in), .tx_end_in(tx_end_in),
  .rx_first_bits_in(rx_first_bits_in), .low_frequency_oscillator_in(low_frequency_oscillator_in),
  .timer2_underflow_flag_out(timer2_underflow_flag_out),
  .timer3_underflow_flag_out(timer3_underflow_flag_out),
  .timer2_underflow_out(timer2_underflow_out), .timer3_underflow_out(timer3_underflow_out),
  .timer2_active_out(timer2_active_out), .timer3_active_out(timer3_active_out));
`default_nettype wire

// ---- test/tb_top.sv ----
// self-checking bench for the timer2/timer3 block
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  // ****************************************************
  // stimulus and observation
  // ****************************************************
  logic mclk = 1'b0; // 10 MHz clock
  logic resetn = 1'b0; // active low reset
  logic [7:0] addr = 8'h00; // register address
  logic [7:0] wdata = 8'h00; // write data
  logic wr = 1'b0; // write strobe
  logic rd = 1'b0; // read strobe
  logic [7:0] t1_low = 8'h00; // live timer1 low byte
  logic low_frequency_oscillator = 1'b0; // trimming oscillator level
  logic [7:0] ev = 8'h00; // pulses: fast, slow, t0, t1, tx, rx, clr2, clr3
  logic [7:0] rdata; // read data
  logic f2, f3, u2, u3, a2, a3; // flags, strobes, run states
  int mismatches = 0; // failed comparisons
  int compares = 0; // comparisons made
  int cyc = 0; // cycle count for the hang guard
  logic [3:0] n2 = 4'h0; // timer2 underflow strobes seen
  logic [3:0] n3 = 4'h0; // timer3 underflow strobes seen
  tcc_timers i_tcc_timers (
    .mclk_in(mclk), .resetn_in(resetn), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .tick_13m56_in(ev[0]),
    .tick_212k_in(ev[1]), .timer0_underflow_in(ev[2]), .timer1_underflow_in(ev[3]),
    .timer1_count_low_in(t1_low), .tx_end_in(ev[4]), .rx_first_bits_in(ev[5]),
    .low_frequency_oscillator_in(low_frequency_oscillator), .timer2_flag_clear_in(ev[6]),
    .timer3_flag_clear_in(ev[7]), .timer2_underflow_flag_out(f2),
    .timer3_underflow_flag_out(f3), .timer2_underflow_out(u2), .timer3_underflow_out(u3),
    .timer2_active_out(a2), .timer3_active_out(a3));
  // clock and hang guard
  always #50 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (u2) n2 <= n2 + 4'h1;
    if (u3) n3 <= n3 + 4'h1;
    if (cyc == 20000) begin
      mismatches++;
      wrap_up();
    end
  end
  // ****************************************************
  // shared tasks
  // ****************************************************
  task chk(string nm, logic [7:0] exp, logic [7:0] got);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one register write, ends settled
  task wr_reg(logic [7:0] a, logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    @(negedge mclk);
  endtask
  // one register read and compare; never during reception
  task rd_chk(string nm, logic [7:0] a, logic [7:0] exp);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(negedge mclk);
    chk(nm, exp, rdata);
  endtask
  // n one-cycle pulses on event line b
  task pulse(int b, int n);
    repeat (n) begin
      @(posedge mclk);
      ev[b] <= 1'b1;
      @(posedge mclk);
      ev[b] <= 1'b0;
    end
    @(negedge mclk);
  endtask
  // set oscillator level, let one edge see it
  task lfo_set(logic v);
    @(posedge mclk);
    low_frequency_oscillator <= v;
    @(posedge mclk);
    @(negedge mclk);
  endtask
  // ****************************************************
  // scenarios
  // ****************************************************
  // reset values, masks, read-only and live bytes
  task t_regs;
    for (int a = 8'h19; a <= 8'h22; a++) rd_chk("reset", a[7:0], 8'h00);
    wr_reg(8'h19, 8'hFF);
    rd_chk("ctrl2 mask", 8'h19, 8'hBB);
    wr_reg(8'h1C, 8'hFF);
    rd_chk("count ro", 8'h1C, 8'h00);
    @(posedge mclk);
    t1_low <= 8'hA5;
    rd_chk("t1 low", 8'h18, 8'hA5);
  endtask
  // timer2 one-shot, gated run write, late reload
  task t_oneshot;
    wr_reg(8'h19, 8'h00);
    wr_reg(8'h1A, 8'h00);
    wr_reg(8'h1B, 8'h03);
    wr_reg(8'h0E, 8'h40);
    chk("gated run", 8'h00, {7'h00, a2});
    wr_reg(8'h0E, 8'h44);
    rd_chk("run bits", 8'h0E, 8'h40);
    wr_reg(8'h1B, 8'h10);
    pulse(1, 2);
    pulse(0, 2);
    rd_chk("count2 lo", 8'h1D, 8'h01);
    rd_chk("count2 hi", 8'h1C, 8'h00);
    pulse(0, 1);
    chk("at zero", 8'h01, {7'h00, a2});
    pulse(0, 1);
    chk("oneshot", 8'h00, {7'h00, a2});
    chk("flag2", 8'h01, {7'h00, f2});
    chk("uf2 count", 8'h01, {4'h0, n2});
    wr_reg(8'h0E, 8'h44);
    rd_chk("new reload", 8'h1D, 8'h10);
    wr_reg(8'h0E, 8'h04);
    chk("sw stop", 8'h00, {7'h00, a2});
  endtask
  // timer2 cascaded from timer0 with auto reload
  task t_cascade;
    wr_reg(8'h19, 8'h0A);
    wr_reg(8'h1B, 8'h01);
    wr_reg(8'h0E, 8'h44);
    pulse(6, 1);
    chk("flag2 clr", 8'h00, {7'h00, f2});
    pulse(3, 2);
    rd_chk("wrong src", 8'h1D, 8'h01);
    pulse(2, 2);
    chk("reload run", 8'h01, {7'h00, a2});
    chk("flag2 set", 8'h01, {7'h00, f2});
    chk("uf2 casc", 8'h02, {4'h0, n2});
    rd_chk("reloaded", 8'h1D, 8'h01);
    wr_reg(8'h0E, 8'h04);
  endtask
  // auto start, stop on receive, trimming modes
  task t_autostart;
    wr_reg(8'h19, 8'h80);
    pulse(4, 1);
    chk("no auto", 8'h00, {7'h00, a2});
    wr_reg(8'h19, 8'h90);
    pulse(4, 1);
    chk("tx start", 8'h01, {7'h00, a2});
    pulse(5, 1);
    chk("rx stop", 8'h00, {7'h00, a2});
    wr_reg(8'h19, 8'h10);
    pulse(4, 1);
    pulse(5, 1);
    chk("rx kept", 8'h01, {7'h00, a2});
    wr_reg(8'h0E, 8'h04);
    for (int m = 2; m < 4; m++) begin
      wr_reg(8'h19, {2'b10, m[1:0], 4'h8});
      lfo_set(1'b1);
      chk("trim start", 8'h01, {7'h00, a2});
      pulse(5, 1);
      chk("trim rx", 8'h01, {7'h00, a2});
      lfo_set(1'b0);
      lfo_set(1'b1);
      chk("trim stop", 8'h00, {7'h00, a2});
      lfo_set(1'b0);
    end
  endtask
  // timer3 slow clock, flag, tx start, cascade, rx stop
  task t_timer3;
    wr_reg(8'h1E, 8'h01);
    wr_reg(8'h1F, 8'h00);
    wr_reg(8'h20, 8'h02);
    wr_reg(8'h0E, 8'h88);
    rd_chk("run bits3", 8'h0E, 8'h80);
    pulse(0, 2);
    rd_chk("slow only", 8'h22, 8'h02);
    pulse(1, 3);
    chk("t3 stop", 8'h00, {7'h00, a3});
    chk("flag3", 8'h01, {7'h00, f3});
    chk("uf3 count", 8'h01, {4'h0, n3});
    pulse(7, 1);
    chk("flag3 clr", 8'h00, {7'h00, f3});
    wr_reg(8'h1E, 8'h93);
    pulse(4, 1);
    chk("t3 tx", 8'h01, {7'h00, a3});
    rd_chk("t3 load", 8'h22, 8'h02);
    pulse(3, 1);
    rd_chk("t3 casc", 8'h22, 8'h01);
    pulse(5, 1);
    chk("t3 rx", 8'h00, {7'h00, a3});
  endtask
  // counts and verdict
  task wrap_up;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    t_regs();
    t_oneshot();
    t_cascade();
    t_autostart();
    t_timer3();
    wrap_up();
  end
endmodule
`default_nettype wire
